// file: watchdog_protect_timer.sv
// Notes on behaviour
// - protect mode clocks the counter from the dedicated ~125 kHz oscillator tick
// - bit 7 of protect_mode_ctrl enables protect mode when 1, disables when 0
// - protect bit resets to 1 when protect_initial_option_bit of option byte one is 0
// - option byte two bits 1:0 pick reload 03ff, 0fff, 1fff or 3fff
// - option byte two bits 3:2 pick refresh window 25, 50, 75 or 100 percent
// - protect-mode timeout equals reload count plus one over the dedicated oscillator frequency
// - option byte one bit 0 low starts counting after reset, high leaves it stopped
// - any write to watchdog_start makes the counter run
// - refresh is the ordered write pair 00h then ffh to watchdog_refresh
// - reset and each refresh inside the window load the counter with the selected reload value
// - protect mode off: counter status returns counter bits 10 to 5
// - protect mode on: status slice follows reload field, 5:0, 8:3, 9:4, 10:5
// - underflow sets bit 3 of voltage_detect_ctrl_two; 0 means none seen
`timescale 1ns/1ps
module watchdog_protect_timer
   import wdt_pkg::*;
#(
   parameter int OSC_DIVIDE = OSC_DIV
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic [DATA_W-1:0] opt_byte_one,
   input  wire logic [DATA_W-1:0] opt_byte_two,
   output logic                   underflow_pulse,
   output logic                   wdt_running,
   output logic                   irq
);

   // the divider needs at least two states and at most sixteen bits
   if (OSC_DIVIDE < 2 || OSC_DIVIDE > 65536) begin : g_bad_divide
      $error("OSC_DIVIDE out of range");
   end

   localparam int DIV_W = $clog2(OSC_DIVIDE);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIVIDE - 1);

   logic              rst_meta_b_r;
   logic              srst_b;
   logic              init_done_r;
   logic [7:0]        opt_one_r;
   logic [7:0]        opt_two_r;
   logic              protect_mode_bit_r;
   logic              running_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [DIV_W-1:0]  div_r;
   logic              armed_r;
   logic              uf_flag_r;
   logic [IRQ_W-1:0]  irq_status_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic [DATA_W-1:0] rd_data_r;
   logic              uf_pulse_r;
   logic              irq_r;

   logic [1:0]        reload_sel;
   logic [1:0]        duty_sel;
   logic [CNT_W-1:0]  reload_val;
   logic [CNT_W:0]    quarter;
   logic [CNT_W+1:0]  win_limit;
   logic              in_window;
   logic              tick;
   logic              underflow;
   logic              wr_refresh;
   logic              refresh_fire;
   logic              refresh_ok;
   logic              refresh_reject;
   logic [SLICE_W-1:0] cnt_slice;
   logic [DATA_W-1:0] rd_nxt;

   // reset release through two flops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b_r <= 1'b0;
         srst_b       <= 1'b0;
      end else begin
         rst_meta_b_r <= 1'b1;
         srst_b       <= rst_meta_b_r;
      end
   end

   // option bytes are caught once, in the first cycle after release
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         init_done_r <= 1'b0;
         opt_one_r   <= RESET_BYTE;
         opt_two_r   <= RESET_BYTE;
      end else if (!init_done_r) begin
         init_done_r <= 1'b1;
         opt_one_r   <= opt_byte_one;
         opt_two_r   <= opt_byte_two;
      end
   end

   assign reload_sel = opt_two_r[OPT2_RELOAD_LSB +: 2];
   assign duty_sel   = opt_two_r[OPT2_DUTY_LSB +: 2];

   always_comb begin
      case (reload_sel)
         2'b00:   reload_val = RELOAD_00;
         2'b01:   reload_val = RELOAD_01;
         2'b10:   reload_val = RELOAD_10;
         default: reload_val = RELOAD_11;
      endcase
   end

   // permitted portion is the last part of the count, just before underflow
   assign quarter = ({1'b0, reload_val} + (CNT_W+1)'(1)) >> 2;
   always_comb begin
      case (duty_sel)
         2'b00:   win_limit = {1'b0, quarter};
         2'b01:   win_limit = {quarter, 1'b0};
         2'b10:   win_limit = {1'b0, quarter} + {quarter, 1'b0};
         default: win_limit = '1;
      endcase
   end
   assign in_window = (duty_sel == 2'b11) || ({2'b00, cnt_r} < win_limit);

   // dedicated oscillator tick
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         div_r <= '0;
      end else if (div_r == DIV_LAST) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + DIV_W'(1);
      end
   end
   assign tick = protect_mode_bit_r ? (div_r == DIV_LAST) : 1'b1;

   assign underflow = init_done_r && running_r && tick && (cnt_r == '0);

   assign wr_refresh     = wr_en && (addr == ADDR_REFRESH);
   assign refresh_fire   = wr_refresh && armed_r && (wr_data == REFRESH_SECOND);
   assign refresh_ok     = refresh_fire && in_window;
   assign refresh_reject = refresh_fire && !in_window;

   // refresh sequence arming
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         armed_r <= 1'b0;
      end else if (wr_refresh) begin
         armed_r <= (wr_data == REFRESH_FIRST);
      end
   end

   // protect mode control
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         protect_mode_bit_r <= 1'b0;
      end else if (!init_done_r) begin
         protect_mode_bit_r <= !opt_byte_one[OPT1_PROT_INIT_BIT];
      end else if (wr_en && addr == ADDR_PROT_CTRL) begin
         protect_mode_bit_r <= wr_data[PROT_MODE_BIT];
      end
   end

   // run state
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         running_r <= 1'b0;
      end else if (!init_done_r) begin
         running_r <= !opt_byte_one[OPT1_AUTO_START_BIT];
      end else if (wr_en && addr == ADDR_START) begin
         running_r <= 1'b1;
      end
   end

   // counter
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         cnt_r <= '0;
      end else if (init_done_r == 1'b0 || refresh_ok || underflow) begin
         cnt_r <= (init_done_r == 1'b0) ? reload_from_opt(opt_byte_two) : reload_val;
      end else if (running_r && tick) begin
         cnt_r <= cnt_r - CNT_W'(1);
      end
   end

   function automatic logic [CNT_W-1:0] reload_from_opt(input logic [7:0] ob);
      case (ob[OPT2_RELOAD_LSB +: 2])
         2'b00:   return RELOAD_00;
         2'b01:   return RELOAD_01;
         2'b10:   return RELOAD_10;
         default: return RELOAD_11;
      endcase
   endfunction

   // underflow detect flag, write 0 clears, a new underflow wins
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         uf_flag_r <= 1'b0;
      end else if (underflow) begin
         uf_flag_r <= 1'b1;
      end else if (wr_en && addr == ADDR_VDET_CTRL2 && !wr_data[UF_FLAG_BIT]) begin
         uf_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         uf_pulse_r <= 1'b0;
      end else begin
         uf_pulse_r <= underflow;
      end
   end

   // interrupt status: write one to clear, set wins
   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         irq_status_r <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_UF_BIT && underflow) || (i == IRQ_REJECT_BIT && refresh_reject)) begin
               irq_status_r[i] <= 1'b1;
            end else if (wr_en && addr == ADDR_IRQ_STATUS && wr_data[i]) begin
               irq_status_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         irq_mask_r <= '0;
      end else if (wr_en && addr == ADDR_IRQ_MASK) begin
         irq_mask_r <= wr_data[IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

   // counter status slice
   always_comb begin
      if (!protect_mode_bit_r) begin
         cnt_slice = cnt_r[SLICE_LSB_STD +: SLICE_W];
      end else begin
         case (reload_sel)
            2'b00:   cnt_slice = cnt_r[SLICE_LSB_00 +: SLICE_W];
            2'b01:   cnt_slice = cnt_r[SLICE_LSB_01 +: SLICE_W];
            2'b10:   cnt_slice = cnt_r[SLICE_LSB_10 +: SLICE_W];
            default: cnt_slice = cnt_r[SLICE_LSB_11 +: SLICE_W];
         endcase
      end
   end

   always_comb begin
      rd_nxt = RESET_BYTE;
      case (addr)
         ADDR_VDET_CTRL2: rd_nxt[UF_FLAG_BIT] = uf_flag_r;
         ADDR_PROT_CTRL:  rd_nxt[PROT_MODE_BIT] = protect_mode_bit_r;
         ADDR_CNT_STATUS: rd_nxt[SLICE_W-1:0] = cnt_slice;
         ADDR_OPT_ONE:    rd_nxt = opt_one_r;
         ADDR_OPT_TWO:    rd_nxt = opt_two_r;
         ADDR_IRQ_STATUS: rd_nxt[IRQ_W-1:0] = irq_status_r;
         ADDR_IRQ_MASK:   rd_nxt[IRQ_W-1:0] = irq_mask_r;
         default:         rd_nxt = RESET_BYTE;
      endcase
   end

   always_ff @(posedge mclk or negedge srst_b) begin
      if (!srst_b) begin
         rd_data_r <= RESET_BYTE;
      end else begin
         rd_data_r <= rd_en ? rd_nxt : RESET_BYTE;
      end
   end

   assign rd_data         = rd_data_r;
   assign underflow_pulse = uf_pulse_r;
   assign wdt_running     = running_r;
   assign irq             = irq_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!srst_b);

   sequence s_arm;
      wr_en && addr == ADDR_REFRESH && wr_data == REFRESH_FIRST;
   endsequence
   sequence s_second;
      wr_en && addr == ADDR_REFRESH && wr_data == REFRESH_SECOND;
   endsequence
   sequence s_uf_seen;
      uf_pulse_r && uf_flag_r;
   endsequence

   a_refresh_pair_reload: assert property (
      s_arm ##1 (s_second and (init_done_r && in_window && !underflow))
      |=> cnt_r == reload_val)
      else $error("ordered refresh pair did not reload counter");
   a_lone_ff_ignored: assert property (
      (s_second and (!armed_r && init_done_r && running_r && !protect_mode_bit_r
       && cnt_r != '0)) |=> cnt_r == $past(cnt_r) - CNT_W'(1))
      else $error("unarmed ffh write changed counter");
   a_reject_window: assert property (
      (refresh_fire && !in_window && running_r && !protect_mode_bit_r && cnt_r != '0)
      |=> cnt_r == $past(cnt_r) - CNT_W'(1) && irq_status_r[IRQ_REJECT_BIT])
      else $error("out-of-window refresh was not ignored");
   a_underflow_flow: assert property (
      underflow |=> s_uf_seen ##1 !uf_pulse_r)
      else $error("underflow pulse or flag wrong");
   a_uf_reload: assert property (
      underflow |=> cnt_r == reload_val)
      else $error("counter not reloaded after underflow");
   a_cpu_decrement: assert property (
      (running_r && !protect_mode_bit_r && init_done_r && cnt_r != '0 && !refresh_ok)
      |=> cnt_r == $past(cnt_r) - CNT_W'(1))
      else $error("counter did not step on cpu clock");
   a_slow_hold: assert property (
      (protect_mode_bit_r && div_r != DIV_LAST && init_done_r && !refresh_ok)
      |=> $stable(cnt_r))
      else $error("counter moved between oscillator ticks");
   a_start_runs: assert property (
      (wr_en && addr == ADDR_START && init_done_r) |=> running_r [*2])
      else $error("start write did not start counter");
   a_status_std: assert property (
      (rd_en && addr == ADDR_CNT_STATUS && !protect_mode_bit_r)
      |=> rd_data_r == {2'b00, $past(cnt_r[SLICE_LSB_STD +: SLICE_W])})
      else $error("status slice wrong with protect off");
   a_status_prot: assert property (
      (rd_en && addr == ADDR_CNT_STATUS && protect_mode_bit_r && reload_sel == 2'b00)
      |=> rd_data_r == {2'b00, $past(cnt_r[SLICE_LSB_00 +: SLICE_W])})
      else $error("status slice wrong with protect on");
   a_prot_write: assert property (
      (wr_en && addr == ADDR_PROT_CTRL && init_done_r)
      |=> protect_mode_bit_r == $past(wr_data[PROT_MODE_BIT]))
      else $error("protect bit not written");
   a_init_state: assert property (
      $rose(init_done_r) |-> running_r == !opt_one_r[OPT1_AUTO_START_BIT]
      && protect_mode_bit_r == !opt_one_r[OPT1_PROT_INIT_BIT])
      else $error("state after reset wrong");
   a_read_once: assert property (
      !rd_en |=> rd_data_r == RESET_BYTE)
      else $error("read data outside read answer cycle");
   a_prot_tick_step: assert property (
      (protect_mode_bit_r && div_r == DIV_LAST && running_r && init_done_r && cnt_r != '0
       && !refresh_ok) |=> cnt_r == $past(cnt_r) - CNT_W'(1))
      else $error("counter did not step on oscillator tick");
   a_slice_code_one: assert property (
      (rd_en && addr == ADDR_CNT_STATUS && protect_mode_bit_r && reload_sel == 2'b01)
      |=> rd_data_r == {2'b00, $past(cnt_r[SLICE_LSB_01 +: SLICE_W])})
      else $error("status slice wrong for reload code one");
   a_slice_code_two: assert property (
      (rd_en && addr == ADDR_CNT_STATUS && protect_mode_bit_r && reload_sel == 2'b10)
      |=> rd_data_r == {2'b00, $past(cnt_r[SLICE_LSB_10 +: SLICE_W])})
      else $error("status slice wrong for reload code two");
   a_slice_code_three: assert property (
      (rd_en && addr == ADDR_CNT_STATUS && protect_mode_bit_r && reload_sel == 2'b11)
      |=> rd_data_r == {2'b00, $past(cnt_r[SLICE_LSB_11 +: SLICE_W])})
      else $error("status slice wrong for reload code three");
   a_flag_clear: assert property (
      (wr_en && addr == ADDR_VDET_CTRL2 && !wr_data[UF_FLAG_BIT] && !underflow)
      |=> !uf_flag_r)
      else $error("underflow flag not cleared by write of zero");
   a_full_window: assert property (
      (refresh_fire && duty_sel == 2'b11 && init_done_r) |=> cnt_r == reload_val)
      else $error("refresh refused with full window");
   a_irq_level: assert property (
      (|(irq_status_r & irq_mask_r)) |=> irq_r)
      else $error("interrupt not raised for unmasked status");

endmodule

// file: wdt_pkg.sv
package wdt_pkg;
   // register bus
   localparam int         ADDR_W           = 20;
   localparam int         DATA_W           = 8;
   localparam logic [19:0] ADDR_VDET_CTRL2 = 20'h0002c;
   localparam logic [19:0] ADDR_PROT_CTRL  = 20'h0037c;
   localparam logic [19:0] ADDR_REFRESH    = 20'h0037d;
   localparam logic [19:0] ADDR_START      = 20'h0037e;
   localparam logic [19:0] ADDR_CNT_STATUS = 20'h0037f;
   localparam logic [19:0] ADDR_OPT_ONE    = 20'h0ffff;
   localparam logic [19:0] ADDR_OPT_TWO    = 20'hfffdb;
   localparam logic [19:0] ADDR_IRQ_STATUS = 20'h003f0;
   localparam logic [19:0] ADDR_IRQ_MASK   = 20'h003f1;

   // field positions
   localparam int PROT_MODE_BIT       = 7;
   localparam int UF_FLAG_BIT         = 3;
   localparam int OPT1_AUTO_START_BIT = 0;
   localparam int OPT1_PROT_INIT_BIT  = 5;
   localparam int OPT2_RELOAD_LSB     = 0;
   localparam int OPT2_DUTY_LSB       = 2;
   localparam int IRQ_UF_BIT          = 0;
   localparam int IRQ_REJECT_BIT      = 1;
   localparam int IRQ_W               = 2;

   // refresh sequence bytes
   localparam logic [7:0] REFRESH_FIRST  = 8'h00;
   localparam logic [7:0] REFRESH_SECOND = 8'hff;

   // counter and reload values
   localparam int          CNT_W     = 14;
   localparam logic [13:0] RELOAD_00 = 14'h03ff;
   localparam logic [13:0] RELOAD_01 = 14'h0fff;
   localparam logic [13:0] RELOAD_10 = 14'h1fff;
   localparam logic [13:0] RELOAD_11 = 14'h3fff;
   localparam int          SLICE_W   = 6;
   localparam int SLICE_LSB_STD = 5;
   localparam int SLICE_LSB_00  = 0;
   localparam int SLICE_LSB_01  = 3;
   localparam int SLICE_LSB_10  = 4;
   localparam int SLICE_LSB_11  = 5;

   // timing: dedicated oscillator tick derived from mclk
   localparam int MCLK_FREQ_KHZ = 100000;
   localparam int WDT_OSC_KHZ   = 125;
   localparam int OSC_DIV       = MCLK_FREQ_KHZ / WDT_OSC_KHZ;

   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// file: tb_watchdog_protect_timer.sv
`timescale 1ns/1ps
module tb_watchdog_protect_timer
   import wdt_pkg::*;
;
   localparam int DIV = 4;
   logic              mclk;
   logic              rst_b;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] opt_byte_one;
   logic [DATA_W-1:0] opt_byte_two;
   logic              underflow_pulse;
   logic              wdt_running;
   logic              irq;
   int                failures;
   int                tests_run;
   int                cyc = 0;
   int                rl [4] = '{1023, 4095, 8191, 16383};
   int                lsb [4] = '{0, 3, 4, 5};

   watchdog_protect_timer #(.OSC_DIVIDE(DIV)) u_dut (
      .mclk            (mclk),
      .rst_b           (rst_b),
      .addr            (addr),
      .wr_data         (wr_data),
      .wr_en           (wr_en),
      .rd_en           (rd_en),
      .rd_data         (rd_data),
      .opt_byte_one    (opt_byte_one),
      .opt_byte_two    (opt_byte_two),
      .underflow_pulse (underflow_pulse),
      .wdt_running     (wdt_running),
      .irq             (irq)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
   end

   task automatic close_out;
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rst(logic [7:0] o1, logic [7:0] o2);
      rst_b <= 1'b0;
      opt_byte_one <= o1;
      opt_byte_two <= o2;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask

   task automatic wr(logic [19:0] a, logic [7:0] v);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask

   // back-to-back refresh pair, strobe held high across both writes
   task automatic refresh_pair;
      addr <= ADDR_REFRESH;
      wr_data <= REFRESH_FIRST;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_data <= REFRESH_SECOND;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(logic [19:0] a, output logic [7:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 d = rd_data;
      @(posedge mclk);
   endtask

   // counts edges until the underflow pulse, then checks it lasted one cycle
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (underflow_pulse !== 1'b1 && n < 70000);
      cmp("uf_seen", 1, underflow_pulse);
      @(posedge mclk);
      #1 cmp("uf_width", 0, underflow_pulse);
      @(posedge mclk);
   endtask

   task automatic chk_irq(logic e);
      @(negedge mclk);
      cmp("irq", e, irq);
      @(posedge mclk);
   endtask

   initial begin
      logic [7:0] o1;
      logic [7:0] o2;
      logic [7:0] d;
      int         n;
      int         t0;
      int         w;
      rst_b = 1'b0;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      opt_byte_one = 8'hff;
      opt_byte_two = 8'hff;
      failures = 0;
      tests_run = 0;
      void'($urandom(66898));
      // reset state against option byte one
      for (int i = 0; i < 4; i++) begin
         o1 = 8'($urandom);
         o1[5] = i[1];
         o1[0] = i[0];
         o2 = 8'($urandom);
         rst(o1, o2);
         @(negedge mclk);
         cmp("running", !i[0], wdt_running);
         @(posedge mclk);
         rd(ADDR_PROT_CTRL, d);
         if (!i[1]) cmp("prot_init", 1, d[7]);
         rd(ADDR_OPT_ONE, d);
         cmp("opt_one", o1, d);
         rd(ADDR_OPT_TWO, d);
         cmp("opt_two", o2, d);
         rd(ADDR_REFRESH, d);
         cmp("wo_read", 0, d);
         rd(20'h00123, d);
         cmp("unmapped", 0, d);
      end
      // reload codes, status slices, periods in both count sources
      for (int c = 0; c < 4; c++) begin
         rst(8'hff, 8'hfc | 8'(c));
         wr(ADDR_PROT_CTRL, 8'h00);
         rd(ADDR_CNT_STATUS, d);
         cmp("slice_std", (rl[c] >> 5) & 63, d);
         wr(ADDR_PROT_CTRL, 8'h80);
         rd(ADDR_PROT_CTRL, d);
         cmp("prot_bit", 8'h80, d & 8'h80);
         rd(ADDR_CNT_STATUS, d);
         cmp("slice_prot", (rl[c] >> lsb[c]) & 63, d);
         if (c < 2) begin
            wr(ADDR_PROT_CTRL, 8'h00);
            wr(ADDR_START, 8'($urandom));
            @(negedge mclk);
            cmp("started", 1, wdt_running);
            @(posedge mclk);
            wait_pulse(n);
            cmp("first_uf", 1, n > rl[c] - 8 && n < rl[c] + 8);
            wait_pulse(n);
            cmp("period", rl[c] + 1, n + 2);
         end
         if (c == 0) begin
            wr(ADDR_PROT_CTRL, 8'h80);
            wait_pulse(n);
            wait_pulse(n);
            cmp("period_prot", (rl[0] + 1) * DIV, n + 2);
         end
      end
      // refresh window per duty: just outside refused for duty 0 to 2, just inside taken
      for (int duty = 0; duty < 4; duty++) begin
         rst(8'hff, 8'hf0 | 8'(duty << 2));
         wr(ADDR_PROT_CTRL, 8'h00);
         wr(ADDR_IRQ_MASK, 8'h00);
         wr(ADDR_START, 8'h5a);
         wait_pulse(n);
         w = (duty == 3) ? 100 : 978 - 256 * (duty + 1);
         repeat (w) @(posedge mclk);
         refresh_pair;
         rd(ADDR_IRQ_STATUS, d);
         cmp("reject", duty < 3, d[1]);
         wr(ADDR_IRQ_STATUS, 8'h02);
         repeat (70) @(posedge mclk);
         wr(ADDR_REFRESH, REFRESH_FIRST);
         rd(ADDR_OPT_ONE, d);
         wr(ADDR_REFRESH, REFRESH_SECOND);
         t0 = cyc;
         rd(ADDR_IRQ_STATUS, d);
         cmp("accept", 0, d[1]);
         wait_pulse(n);
         cmp("refresh_reload", 1, cyc - t0 > 1016 && cyc - t0 < 1036);
      end
      // broken and disarmed sequences leave the count alone
      t0 = cyc;
      repeat (850) @(posedge mclk);
      wr(ADDR_REFRESH, REFRESH_SECOND);
      wr(ADDR_REFRESH, REFRESH_FIRST);
      wr(ADDR_REFRESH, 8'h55);
      wr(ADDR_REFRESH, REFRESH_SECOND);
      wait_pulse(n);
      cmp("no_refresh", rl[0] + 1, cyc - t0);
      // underflow flag and interrupt
      rd(ADDR_VDET_CTRL2, d);
      cmp("uf_flag", 1, d[3]);
      wr(ADDR_VDET_CTRL2, 8'h00);
      rd(ADDR_VDET_CTRL2, d);
      cmp("uf_flag_clr", 0, d[3]);
      rd(ADDR_IRQ_STATUS, d);
      cmp("irq_status", 1, d[0]);
      chk_irq(1'b0);
      wr(ADDR_IRQ_MASK, 8'h01);
      chk_irq(1'b1);
      wr(ADDR_IRQ_STATUS, 8'h03);
      chk_irq(1'b0);
      rd(ADDR_IRQ_STATUS, d);
      cmp("irq_clr", 0, d);
      close_out;
   end

   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      close_out;
   end
endmodule
